// file: inc/lp_ctrl_pkg.sv
package lp_ctrl_pkg;
   // ----------------------------------------
   // Interrupt option register layout
   // ----------------------------------------
   localparam logic [7:0] INT_OPT_ADDR = 8'hc8;
   localparam int GLOBAL_EN_BIT = 4;
   localparam logic [7:0] INT_OPT_RESET = 8'h00;
   // ----------------------------------------
   // Timing and source count
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int OSC_SETTLE_CYCLES = 64;
   localparam int NUM_SOURCES = 5;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_IDLE = 2'b01,
      ST_STOP = 2'b10,
      ST_SETTLE = 2'b11
   } pm_state_e;

   typedef enum logic [1:0] {
      CTX_MAIN = 2'b00,
      CTX_MASKABLE = 2'b01,
      CTX_NMI = 2'b10
   } core_ctx_e;

   typedef enum logic [1:0] {
      EXIT_NONE = 2'b00,
      EXIT_SERVICE = 2'b01,
      EXIT_RESUME = 2'b10,
      EXIT_NMI_THEN_RESUME = 2'b11
   } exit_action_e;
endpackage

// file: verilog/wake_request.sv
`timescale 1ns/1ps
`default_nettype none
module wake_request #(
   parameter int N = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [N-1:0] irq_req,
   input wire logic [N-1:0] irq_en,
   input wire logic nmi_req,
   input wire logic global_interrupt_enable,
   output logic wake,
   output logic maskable_pending,
   output logic nmi_wake
);
   logic [N-1:0] gated;
   logic unused_clk;

   assign unused_clk = clk ^ rst;

   // ----------------------------------------
   // Per-source gating
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_src
         assign gated[i] = irq_req[i] & irq_en[i];
      end
   endgenerate

   // Global enable gates the non-maskable line too, for wake purposes only
   assign maskable_pending = global_interrupt_enable & (|gated);
   assign nmi_wake = global_interrupt_enable & nmi_req;
   assign wake = maskable_pending | nmi_wake;
endmodule // wake_request
`default_nettype wire

// file: verilog/settle_counter.sv
`timescale 1ns/1ps
`default_nettype none
module settle_counter #(
   parameter int COUNT = 64
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   output logic done
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic busy_ff;
   logic nxt_busy;

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_busy = busy_ff;
      if (start) begin
         nxt_cnt = W'(COUNT - 1);
         nxt_busy = 1'b1;
      end else if (busy_ff) begin
         if (cnt_ff == '0) begin
            nxt_busy = 1'b0;
         end else begin
            nxt_cnt = cnt_ff - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end

   assign done = busy_ff && (cnt_ff == '0) && !start;
endmodule // settle_counter
`default_nettype wire

// file: verilog/low_power_wait_stop_control.sv
// Summary of operation
// - Idle instruction freezes core, keeps state
// - Idle keeps oscillator and peripheral clocks
// - Enabled peripheral interrupt ends idle
// - Idle exit has no settle delay
// - Pin or watchdog reset aborts idle
// - Stop halts oscillator, waits interrupt/reset
// - Stop exit by interrupt waits oscillator settle delay
// - Pin reset ends stop state
// - Active watchdog turns stop into idle
// - Main context: service interrupt, then continue
// - NMI context: wake, continue, no service
// - Maskable context, maskable wake: resume routine
// - Maskable context, NMI-only wake: NMI first
// - Wake leaves oscillator selection unchanged
// - Global enable low: only reset restarts
// - Pending enabled request cancels mode instruction
// - Write-only global enable in option register
`timescale 1ns/1ps
`default_nettype none
module low_power_wait_stop_control
   import lp_ctrl_pkg::*;
#(
   parameter int N_SRC = lp_ctrl_pkg::NUM_SOURCES,
   parameter int SETTLE = lp_ctrl_pkg::OSC_SETTLE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_reset_pin,
   input wire logic wdg_reset,
   input wire logic wdg_active,
   input wire logic wait_instr,
   input wire logic stop_instr,
   input wire lp_ctrl_pkg::core_ctx_e core_ctx,
   input wire logic [N_SRC-1:0] irq_req,
   input wire logic [N_SRC-1:0] irq_en,
   input wire logic nmi_req,
   input wire logic opt_wr,
   input wire logic [7:0] opt_addr,
   input wire logic [7:0] opt_wdata,
   input wire logic osc_sel_in,
   output logic core_halt,
   output logic osc_enable,
   output logic periph_clk_en,
   output logic core_reset,
   output logic resume_pulse,
   output lp_ctrl_pkg::exit_action_e exit_action,
   output logic global_interrupt_enable,
   output logic osc_sel,
   output lp_ctrl_pkg::pm_state_e pm_state
);
   import lp_ctrl_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] pin_sync_ff;
   logic [1:0] nmi_sync_ff;
   logic [N_SRC-1:0] irq_sync1_ff;
   logic [N_SRC-1:0] irq_sync2_ff;
   logic pin_rst;
   logic nmi_s;

   always_ff @(posedge clk) begin
      pin_sync_ff <= {pin_sync_ff[0], ext_reset_pin};
      nmi_sync_ff <= {nmi_sync_ff[0], nmi_req};
      irq_sync1_ff <= irq_req;
      irq_sync2_ff <= irq_sync1_ff;
   end

   assign pin_rst = pin_sync_ff[1];
   assign nmi_s = nmi_sync_ff[1];

   // ----------------------------------------
   // Interrupt option register (write only)
   // ----------------------------------------
   logic gen_ff;
   logic nxt_gen;

   always_comb begin
      nxt_gen = gen_ff;
      if (opt_wr && opt_addr == INT_OPT_ADDR) begin
         nxt_gen = opt_wdata[GLOBAL_EN_BIT];
      end
   end

   // ----------------------------------------
   // Wake logic and settle counter
   // ----------------------------------------
   logic wake;
   logic mask_pend;
   logic nmi_wake;
   logic settle_start;
   logic settle_done;
   logic any_reset;

   assign any_reset = rst | pin_rst | wdg_reset;

   wake_request #(
      .N(N_SRC)
   ) u_wake (
      .clk(clk),
      .rst(any_reset),
      .irq_req(irq_sync2_ff),
      .irq_en(irq_en),
      .nmi_req(nmi_s),
      .global_interrupt_enable(gen_ff),
      .wake(wake),
      .maskable_pending(mask_pend),
      .nmi_wake(nmi_wake)
   );

   settle_counter #(
      .COUNT(SETTLE)
   ) u_settle (
      .clk(clk),
      .rst(any_reset),
      .start(settle_start),
      .done(settle_done)
   );

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   pm_state_e state_ff;
   pm_state_e nxt_state;
   core_ctx_e ctx_ff;
   core_ctx_e nxt_ctx;
   logic nmi_woke_ff;
   logic nxt_nmi_woke;
   logic resume_ff;
   logic nxt_resume;
   exit_action_e action_ff;
   exit_action_e nxt_action;
   logic rst_out_ff;
   logic osc_sel_ff;
   logic nxt_osc_sel;

   function automatic exit_action_e pick_exit(input core_ctx_e c, input logic by_nmi);
      exit_action_e a;
      a = EXIT_SERVICE;
      if (c == CTX_NMI) begin
         a = EXIT_RESUME;
      end else if (c == CTX_MASKABLE) begin
         a = by_nmi ? EXIT_NMI_THEN_RESUME : EXIT_RESUME;
      end
      return a;
   endfunction

   always_comb begin
      nxt_state = state_ff;
      nxt_ctx = ctx_ff;
      nxt_nmi_woke = nmi_woke_ff;
      nxt_resume = 1'b0;
      nxt_action = action_ff;
      nxt_osc_sel = osc_sel_ff;
      settle_start = 1'b0;
      unique case (state_ff)
         ST_RUN: begin
            nxt_osc_sel = osc_sel_in;
            // Any enabled request at the instruction cancels it
            if ((wait_instr || stop_instr) && !wake) begin
               nxt_ctx = core_ctx;
               nxt_action = EXIT_NONE;
               if (stop_instr && !wdg_active) begin
                  nxt_state = ST_STOP;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_IDLE: begin
            // Clock runs, so resume without any settle delay
            if (wake) begin
               nxt_state = ST_RUN;
               nxt_resume = 1'b1;
               nxt_action = pick_exit(ctx_ff, nmi_wake && !mask_pend);
            end
         end
         ST_STOP: begin
            if (wake) begin
               nxt_nmi_woke = nmi_wake && !mask_pend;
               settle_start = 1'b1;
               nxt_state = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (settle_done) begin
               nxt_state = ST_RUN;
               nxt_resume = 1'b1;
               nxt_action = pick_exit(ctx_ff, nmi_woke_ff);
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      // Pin and watchdog resets abort idle and stop alike
      if (any_reset) begin
         state_ff <= ST_RUN;
         ctx_ff <= CTX_MAIN;
         nmi_woke_ff <= 1'b0;
         resume_ff <= 1'b0;
         action_ff <= EXIT_NONE;
         gen_ff <= 1'b0;
         osc_sel_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ctx_ff <= nxt_ctx;
         nmi_woke_ff <= nxt_nmi_woke;
         resume_ff <= nxt_resume;
         action_ff <= nxt_action;
         gen_ff <= nxt_gen;
         osc_sel_ff <= nxt_osc_sel;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rst_out_ff <= 1'b1;
      end else begin
         rst_out_ff <= pin_rst | wdg_reset;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic halt_ff;
   logic osc_en_ff;
   logic pclk_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         halt_ff <= 1'b0;
         osc_en_ff <= 1'b1;
         pclk_ff <= 1'b1;
      end else begin
         halt_ff <= (nxt_state != ST_RUN) && !(pin_rst | wdg_reset);
         osc_en_ff <= (nxt_state != ST_STOP) || pin_rst || wdg_reset;
         pclk_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_IDLE) || pin_rst
            || wdg_reset;
      end
   end

   assign core_halt = halt_ff;
   assign osc_enable = osc_en_ff;
   assign periph_clk_en = pclk_ff;
   assign core_reset = rst_out_ff;
   assign resume_pulse = resume_ff;
   assign exit_action = action_ff;
   assign global_interrupt_enable = gen_ff;
   assign osc_sel = osc_sel_ff;
   assign pm_state = state_ff;
endmodule // low_power_wait_stop_control
`default_nettype wire

// file: dv/lp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lp_checker
   import lp_ctrl_pkg::*;
#(
   parameter int SETTLE = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_reset_pin,
   input wire logic wdg_reset,
   input wire logic wdg_active,
   input wire logic stop_instr,
   input wire logic opt_wr,
   input wire logic [7:0] opt_addr,
   input wire logic [7:0] opt_wdata,
   input wire logic core_halt,
   input wire logic osc_enable,
   input wire logic periph_clk_en,
   input wire logic core_reset,
   input wire logic resume_pulse,
   input wire logic global_interrupt_enable,
   input wire logic osc_sel,
   input wire lp_ctrl_pkg::pm_state_e pm_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ----
   // Settle length, counted here since it outruns a repetition
   // ----
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   always_comb begin
      nxt_cnt = (pm_state == ST_SETTLE) ? cnt_ff + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk) begin
      cnt_ff <= rst ? 8'h00 : nxt_cnt;
   end
   chk_stop_clk_off: assert property (pm_state == ST_STOP |-> !osc_enable && !periph_clk_en)
      else $error("clocks running in stop");
   chk_idle_clk_on: assert property (pm_state == ST_IDLE |-> osc_enable && periph_clk_en)
      else $error("clocks stopped in idle");
   chk_idle_halted: assert property ($past(pm_state) == ST_IDLE && pm_state == ST_IDLE |-> core_halt)
      else $error("core not halted in idle");
   chk_idle_no_settle: assert property (pm_state == ST_IDLE |=> pm_state != ST_SETTLE)
      else $error("settle delay after idle");
   chk_wdg_no_stop: assert property (stop_instr && wdg_active |=> pm_state != ST_STOP)
      else $error("stop entered with watchdog on");
   chk_settle_len: assert property (pm_state == ST_RUN && $past(pm_state) == ST_SETTLE && !core_reset |-> cnt_ff == 8'(SETTLE))
      else $error("settle length wrong");
   chk_wdg_aborts: assert property (wdg_reset |=> core_reset && pm_state == ST_RUN && !global_interrupt_enable)
      else $error("watchdog reset not taken");
   chk_gen_write: assert property (opt_wr && opt_addr == INT_OPT_ADDR && !wdg_reset |=> global_interrupt_enable == $past(opt_wdata[GLOBAL_EN_BIT]))
      else $error("global enable not written");
   chk_gen_low_hold: assert property (pm_state == ST_IDLE && !global_interrupt_enable && !wdg_reset && !ext_reset_pin |=> pm_state == ST_IDLE)
      else $error("woke with global enable low");
   chk_resume_once: assert property (resume_pulse |-> pm_state == ST_RUN && !core_halt ##1 !resume_pulse)
      else $error("resume pulse malformed");
   chk_osc_sel_hold: assert property ($past(pm_state) inside {ST_IDLE, ST_STOP} && pm_state inside {ST_IDLE, ST_STOP} |-> $stable(osc_sel))
      else $error("oscillator selection moved");
   cov_settle: cover property (pm_state == ST_SETTLE);
   cov_wdg_stop: cover property (stop_instr && wdg_active);
   cov_resume: cover property (resume_pulse);
endmodule // lp_checker
bind low_power_wait_stop_control lp_checker #(.SETTLE(SETTLE)) u_chk (.clk(clk), .rst(rst),
   .ext_reset_pin(ext_reset_pin), .wdg_reset(wdg_reset), .wdg_active(wdg_active),
   .stop_instr(stop_instr), .opt_wr(opt_wr), .opt_addr(opt_addr), .opt_wdata(opt_wdata),
   .core_halt(core_halt), .osc_enable(osc_enable), .periph_clk_en(periph_clk_en),
   .core_reset(core_reset), .resume_pulse(resume_pulse),
   .global_interrupt_enable(global_interrupt_enable), .osc_sel(osc_sel), .pm_state(pm_state));
`default_nettype wire

// file: dv/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model
   import lp_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic use_stop,
   input wire lp_ctrl_pkg::core_ctx_e ctx_in,
   input wire lp_ctrl_pkg::pm_state_e pm_state,
   output logic wait_instr = 1'h0,
   output logic stop_instr = 1'h0,
   output lp_ctrl_pkg::core_ctx_e core_ctx = CTX_MAIN
);
   // A frozen core fetches nothing, so pulses go out only in run
   always @(posedge clk) begin
      wait_instr <= go && !use_stop && pm_state == ST_RUN;
      stop_instr <= go && use_stop && pm_state == ST_RUN;
      core_ctx <= ctx_in;
   end
endmodule // core_model
`default_nettype wire

// file: dv/low_power_wait_stop_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module low_power_wait_stop_control_tb_top;
   import lp_ctrl_pkg::*;
   typedef struct packed {core_ctx_e c; logic s; logic w; logic n; pm_state_e st;
      exit_action_e ex;} row_s;
   row_s rows [6] = '{'{CTX_MAIN, 1'h0, 1'h0, 1'h0, ST_IDLE, EXIT_SERVICE},
      '{CTX_NMI, 1'h1, 1'h0, 1'h0, ST_STOP, EXIT_RESUME},
      '{CTX_MASKABLE, 1'h0, 1'h0, 1'h0, ST_IDLE, EXIT_RESUME},
      '{CTX_MASKABLE, 1'h1, 1'h0, 1'h1, ST_STOP, EXIT_NMI_THEN_RESUME},
      '{CTX_MAIN, 1'h1, 1'h1, 1'h0, ST_IDLE, EXIT_SERVICE},
      '{CTX_MAIN, 1'h0, 1'h0, 1'h1, ST_IDLE, EXIT_SERVICE}};
   logic clk = 1'h0, rst = 1'h1, ext_reset_pin = 1'h0, wdg_reset = 1'h0, wdg_active = 1'h0;
   logic go = 1'h0, use_stop = 1'h0, nmi_req = 1'h0, opt_wr = 1'h0, osc_sel_in = 1'h0;
   logic [7:0] opt_addr = 8'h00, opt_wdata = 8'h00;
   logic [NUM_SOURCES-1:0] irq_req = '0, irq_en = '0;
   core_ctx_e ctx_in = CTX_MAIN, core_ctx;
   logic wait_instr, stop_instr, core_halt, osc_enable, periph_clk_en, core_reset;
   logic resume_pulse, global_interrupt_enable, osc_sel;
   exit_action_e exit_action;
   pm_state_e pm_state;
   int failures = 0, comparisons = 0;
   always #10 clk = ~clk;
   core_model u_core (.clk(clk), .go(go), .use_stop(use_stop), .ctx_in(ctx_in),
      .pm_state(pm_state), .wait_instr(wait_instr), .stop_instr(stop_instr), .core_ctx(core_ctx));
   low_power_wait_stop_control #(.SETTLE(4)) uut (.clk(clk), .rst(rst),
      .ext_reset_pin(ext_reset_pin), .wdg_reset(wdg_reset), .wdg_active(wdg_active),
      .wait_instr(wait_instr), .stop_instr(stop_instr), .core_ctx(core_ctx),
      .irq_req(irq_req), .irq_en(irq_en), .nmi_req(nmi_req), .opt_wr(opt_wr),
      .opt_addr(opt_addr), .opt_wdata(opt_wdata), .osc_sel_in(osc_sel_in),
      .core_halt(core_halt), .osc_enable(osc_enable), .periph_clk_en(periph_clk_en),
      .core_reset(core_reset), .resume_pulse(resume_pulse), .exit_action(exit_action),
      .global_interrupt_enable(global_interrupt_enable), .osc_sel(osc_sel), .pm_state(pm_state));
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic set_gen(logic [7:0] a, logic g);
      @(posedge clk);
      opt_wr <= 1'h1;
      opt_addr <= a;
      opt_wdata <= 8'(g) << GLOBAL_EN_BIT;
      tick(1);
      opt_wr <= 1'h0;
   endtask
   task automatic issue(logic s, core_ctx_e c);
      @(posedge clk);
      go <= 1'h1;
      use_stop <= s;
      ctx_in <= c;
      tick(1);
      go <= 1'h0;
      tick(3);
   endtask
   task automatic drop();
      irq_req <= '0;
      nmi_req <= 1'h0;
      tick(4);
   endtask
   task automatic tally_and_finish();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end
   initial begin
      int k;
      tick(5);
      rst <= 1'h0;
      tick(3);
      set_gen(INT_OPT_ADDR, 1'h1);
      irq_en <= 5'h01;
      foreach (rows[i]) begin
         wdg_active <= rows[i].w;
         issue(rows[i].s, rows[i].c);
         `CHK(pm_state, rows[i].st)
         `CHK(core_halt, 1'h1)
         `CHK(periph_clk_en, !(rows[i].s && !rows[i].w))
         osc_sel_in <= ~osc_sel_in;
         if (rows[i].n) nmi_req <= 1'h1;
         else irq_req <= 5'h01;
         k = 0;
         while (resume_pulse !== 1'h1 && k < 40) begin
            @(negedge clk);
            k++;
         end
         `CHK(resume_pulse, 1'h1)
         `CHK(exit_action, rows[i].ex)
         `CHK(osc_sel, ~osc_sel_in)
         @(posedge clk);
         drop();
         $display("row %0d done", i);
      end
      wdg_active <= 1'h0;
      irq_req <= 5'h01;
      tick(4);
      issue(1'h0, CTX_MAIN);
      `CHK(pm_state, ST_RUN)
      drop();
      $display("pending test done");
      set_gen(INT_OPT_ADDR, 1'h0);
      issue(1'h0, CTX_MAIN);
      irq_req <= 5'h01;
      nmi_req <= 1'h1;
      tick(10);
      `CHK(pm_state, ST_IDLE)
      wdg_reset <= 1'h1;
      tick(1);
      wdg_reset <= 1'h0;
      tick(2);
      `CHK(pm_state, ST_RUN)
      drop();
      $display("gen low test done");
      set_gen(INT_OPT_ADDR, 1'h1);
      issue(1'h1, CTX_MAIN);
      `CHK(pm_state, ST_STOP)
      ext_reset_pin <= 1'h1;
      tick(3);
      ext_reset_pin <= 1'h0;
      tick(5);
      `CHK(pm_state, ST_RUN)
      $display("pin reset test done");
      rst <= 1'h1;
      tick(2);
      `CHK(core_reset, 1'h1)
      rst <= 1'h0;
      tick(3);
      set_gen(8'hc9, 1'h1);
      tick(1);
      `CHK(global_interrupt_enable, 1'h0)
      `CHK(osc_enable, 1'h1)
      $display("reset test done");
      tally_and_finish();
   end
endmodule // low_power_wait_stop_control_tb_top
`default_nettype wire
